// ==== bqc_pkg.sv ====
// Constants and types shared by the basic QoS and tag classifier
package bqc_pkg;
	localparam logic [15:0] C_TAG_TPID      = 16'h8100;
	localparam logic [15:0] S_TAG_TPID      = 16'h88a8;
	localparam logic [15:0] CUSTOM_TPID_RST = 16'h88a8;
	// Register byte offsets
	localparam logic [11:0] OFS_CUSTOM_TPID = 12'h000;
	localparam logic [11:0] OFS_FRAME_COUNT = 12'h004;
	localparam logic [11:0] OFS_FLOW_CFG    = 12'h080;
	localparam logic [11:0] OFS_TAG_DFLT    = 12'h0c0;
	localparam logic [11:0] OFS_PRIO_MAP    = 12'h400;
	localparam logic [11:0] OFS_CODEPOINT   = 12'h800;
	localparam logic [11:0] OFS_REWRITE     = 12'h900;
	// Flow config fields
	localparam int FC_QOS_LSB   = 0;
	localparam int FC_DP        = 3;
	localparam int FC_PCP_EN    = 4;
	localparam int FC_DSCP_EN   = 5;
	localparam int FC_XLAT_EN   = 6;
	localparam int FC_REWR_EN   = 7;
	localparam int FC_SECOND    = 8;
	localparam int FC_PRIO_QOS  = 9;
	localparam int FC_STRIP_LSB = 10;
	localparam int FC_L3_EN     = 12;
	localparam int FC_W         = 13;
	localparam logic [FC_W-1:0] FLOW_CFG_RST = 13'h1000;
	// Tag default fields
	localparam int TD_VID_LSB = 0;
	localparam int TD_DEI     = 12;
	localparam int TD_PCP_LSB = 13;
	localparam int TD_S_TAG   = 16;
	localparam int TD_W       = 17;
	localparam logic [TD_W-1:0] TAG_DFLT_RST = 17'h00001;
	// Codepoint config fields
	localparam int CP_XLAT_LSB = 0;
	localparam int CP_TRUST    = 6;
	localparam int CP_QOS_LSB  = 7;
	localparam int CP_DP       = 10;
	localparam int CP_W        = 11;
	localparam logic [CP_W-1:0] CODEPOINT_RST = 11'h000;
	localparam logic [3:0] PRIO_MAP_RST = 4'h0;
	localparam logic [5:0] REWRITE_RST  = 6'h00;
	// Register regions
	typedef enum logic [7:0] {
		BQC_R_NONE  = 8'h01,
		BQC_R_TPID  = 8'h02,
		BQC_R_COUNT = 8'h04,
		BQC_R_FLOW  = 8'h08,
		BQC_R_TAG   = 8'h10,
		BQC_R_MAP   = 8'h20,
		BQC_R_CP    = 8'h40,
		BQC_R_REWR  = 8'h80
	} bqc_region_e;
endpackage : bqc_pkg

// ==== bqc_tag_sel.sv ====
// Tag recognition, tag counting and tag selection
`timescale 1ns/1ps
`default_nettype none
module bqc_tag_sel (
	input  wire logic [15:0] tpid_outer,
	input  wire logic [15:0] tci_outer,
	input  wire logic [15:0] tpid_inner,
	input  wire logic [15:0] tci_inner,
	input  wire logic [15:0] tpid_third,
	input  wire logic [15:0] custom_tpid,
	input  wire logic        use_second,
	output logic [1:0]       tag_cnt,
	output logic             tag_found,
	output logic             tag_s,
	output logic [2:0]       tag_pcp,
	output logic             tag_dei,
	output logic [11:0]      tag_vid
);
	// Returns {is_tag, is_service_tag}
	function automatic logic [1:0] tpid_kind(input logic [15:0] t, input logic [15:0] cst);
		logic s;
		s = (t == bqc_pkg::S_TAG_TPID) || (t == cst);
		tpid_kind = {s || (t == bqc_pkg::C_TAG_TPID), s};
	endfunction : tpid_kind

	logic [1:0] k0;
	logic [1:0] k1;
	logic [1:0] k2;
	logic       pick_inner;

	// A tag counts only if every tag ahead of it was a tag too
	always_comb
	begin
		k0 = tpid_kind(tpid_outer, custom_tpid);
		k1 = tpid_kind(tpid_inner, custom_tpid);
		k2 = tpid_kind(tpid_third, custom_tpid);
		if (!k0[1])
			tag_cnt = 2'd0;
		else if (!k1[1])
			tag_cnt = 2'd1;
		else if (!k2[1])
			tag_cnt = 2'd2;
		else
			tag_cnt = 2'd3; // Three means more than two
		pick_inner = use_second && (tag_cnt >= 2'd2);
		tag_found  = k0[1];
		// Zero VID priority tags are taken the same way as VLAN tags
		tag_s   = pick_inner ? k1[0] : k0[0];
		tag_pcp = pick_inner ? tci_inner[15:13] : tci_outer[15:13];
		tag_dei = pick_inner ? tci_inner[12] : tci_outer[12];
		tag_vid = pick_inner ? tci_inner[11:0] : tci_outer[11:0];
	end
endmodule : bqc_tag_sel
`default_nettype wire

// ==== bqc_dscp_xlat.sv ====
// Shared codepoint translation feeding class, precedence and codepoint
`timescale 1ns/1ps
`default_nettype none
module bqc_dscp_xlat (
	input  wire logic [5:0]             dscp_in,
	input  wire logic                   xlat_en,
	input  wire logic [bqc_pkg::CP_W-1:0] cp_cfg,
	output logic [5:0]                  dscp_out,
	output logic                        trusted,
	output logic [2:0]                  cp_qos,
	output logic                        cp_dp
);
	// One lookup serves all three results so they never disagree
	always_comb
	begin
		dscp_out = xlat_en ? cp_cfg[bqc_pkg::CP_XLAT_LSB +: 6] : dscp_in;
		trusted  = cp_cfg[bqc_pkg::CP_TRUST];
		cp_qos   = cp_cfg[bqc_pkg::CP_QOS_LSB +: 3];
		cp_dp    = cp_cfg[bqc_pkg::CP_DP];
	end
endmodule : bqc_dscp_xlat
`default_nettype wire

// ==== bqc_classifier.sv ====
// Basic QoS, drop precedence, codepoint and tag header classifier
//
// Overview of operation
// - Emit 3-bit class, seven highest priority
// - Emit 1-bit drop precedence, one drops first
// - Raise drop precedence on committed rate excess
// - Emit 6-bit codepoint, meaningful for IP only
// - Codepoint defaults to frame's; zero if not IP
// - Use tag priority bits, inner optionally
// - Take codepoint behind up to two tags
// - Per-port priority map by DEI and PCP
// - Per-codepoint config and class rewrite table
// - One shared codepoint translation for all results
// - Later match stage may replace class results
// - Tag header: PCP, DEI, VID, tag kind
// - Recognise 0x8100, 0x88a8 and custom service TPID
// - Nonzero VID VLAN tag, zero priority tag
// - Tag header from frame or port default
// - Per-port inner or outer tag choice
// - Egress strip count clamped to tags present
// - Optionally class replaces classified PCP
// - Later match stage may replace tag header
// - More than two tags means not IP
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bqc_classifier #(
	parameter int NPORTS = 11,
	parameter int PW     = 4
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Frame header from the parser
	input  wire logic        frm_valid,
	input  wire logic [PW-1:0] frm_port,
	input  wire logic [15:0] frm_tpid_outer,
	input  wire logic [15:0] frm_tci_outer,
	input  wire logic [15:0] frm_tpid_inner,
	input  wire logic [15:0] frm_tci_inner,
	input  wire logic [15:0] frm_tpid_third,
	input  wire logic        frm_is_ip,
	input  wire logic [5:0]  frm_dscp,
	// Policer verdict and match stage overrides for the same frame
	input  wire logic        frm_cir_exceed,
	input  wire logic        ovr_cls_en,
	input  wire logic [2:0]  ovr_qos,
	input  wire logic        ovr_drop_precedence,
	input  wire logic [5:0]  ovr_dscp,
	input  wire logic        ovr_tag_en,
	input  wire logic        ovr_tag_s,
	input  wire logic [2:0]  ovr_pcp,
	input  wire logic        ovr_dei,
	input  wire logic [11:0] ovr_vid,
	// Classification result
	output logic             cls_valid,
	output logic [2:0]       cls_qos,
	output logic             cls_drop_precedence,
	output logic [5:0]       cls_dscp,
	output logic             cls_tag_s,
	output logic [2:0]       cls_pcp,
	output logic             cls_dei,
	output logic [11:0]      cls_vid,
	output logic [1:0]       cls_egress_strip_count
);
	localparam int FCW = bqc_pkg::FC_W;
	localparam int TDW = bqc_pkg::TD_W;
	localparam int CPW = bqc_pkg::CP_W;

	// Configuration storage
	logic [15:0]    custom_service_tpid_q;
	logic [15:0]    custom_service_tpid_d;
	logic [FCW-1:0] port_classification_flow_config [NPORTS];
	logic [TDW-1:0] port_tag_default_config [NPORTS];
	logic [3:0]     tag_priority_map_table [NPORTS*16];
	logic [CPW-1:0] per_codepoint_config [64];
	logic [5:0]     codepoint_rewrite_table [16];
	logic [31:0]    frame_count_q;
	logic [31:0]    frame_count_d;
	logic [31:0]    rdata_q;
	logic [31:0]    rdata_d;

	// Map an address onto its register region
	function automatic bqc_pkg::bqc_region_e region_of(input logic [11:0] a);
		if (a == bqc_pkg::OFS_CUSTOM_TPID)
			region_of = bqc_pkg::BQC_R_TPID;
		else if (a == bqc_pkg::OFS_FRAME_COUNT)
			region_of = bqc_pkg::BQC_R_COUNT;
		else if (a[11:6] == bqc_pkg::OFS_FLOW_CFG[11:6])
			region_of = bqc_pkg::BQC_R_FLOW;
		else if (a[11:6] == bqc_pkg::OFS_TAG_DFLT[11:6])
			region_of = bqc_pkg::BQC_R_TAG;
		else if (a[11:10] == bqc_pkg::OFS_PRIO_MAP[11:10])
			region_of = bqc_pkg::BQC_R_MAP;
		else if (a[11:8] == bqc_pkg::OFS_CODEPOINT[11:8])
			region_of = bqc_pkg::BQC_R_CP;
		else if (a[11:6] == bqc_pkg::OFS_REWRITE[11:6])
			region_of = bqc_pkg::BQC_R_REWR;
		else
			region_of = bqc_pkg::BQC_R_NONE;
	endfunction : region_of

	// Port index check, out-of-range ports hit nothing
	function automatic logic port_ok(input logic [3:0] p);
		port_ok = (32'(p) < NPORTS);
	endfunction : port_ok

	bqc_pkg::bqc_region_e wr_reg;
	bqc_pkg::bqc_region_e rd_reg;
	logic [3:0]           wr_pix;
	logic [3:0]           rd_pix;
	logic [7:0]           wr_mix;
	logic [7:0]           rd_mix;

	// Address decode for both strobes
	always_comb
	begin
		wr_reg = region_of(reg_addr);
		rd_reg = region_of(reg_addr);
		wr_pix = reg_addr[5:2];
		rd_pix = reg_addr[5:2];
		wr_mix = reg_addr[9:2];
		rd_mix = reg_addr[9:2];
	end

	// Register writes into the table memories
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NPORTS; i++)
			begin
				port_classification_flow_config[i] <= bqc_pkg::FLOW_CFG_RST;
				port_tag_default_config[i]         <= bqc_pkg::TAG_DFLT_RST;
			end
			for (int i = 0; i < NPORTS*16; i++)
				tag_priority_map_table[i] <= bqc_pkg::PRIO_MAP_RST;
			for (int i = 0; i < 64; i++)
				per_codepoint_config[i] <= bqc_pkg::CODEPOINT_RST;
			for (int i = 0; i < 16; i++)
				codepoint_rewrite_table[i] <= bqc_pkg::REWRITE_RST;
		end
		else if (reg_wr)
		begin
			case (wr_reg)
				bqc_pkg::BQC_R_FLOW:
					if (port_ok(wr_pix))
						port_classification_flow_config[wr_pix] <= reg_wdata[FCW-1:0];
				bqc_pkg::BQC_R_TAG:
					if (port_ok(wr_pix))
						port_tag_default_config[wr_pix] <= reg_wdata[TDW-1:0];
				bqc_pkg::BQC_R_MAP:
					if (port_ok(wr_mix[7:4]))
						tag_priority_map_table[wr_mix] <= reg_wdata[3:0];
				bqc_pkg::BQC_R_CP:
					per_codepoint_config[wr_mix[5:0]] <= reg_wdata[CPW-1:0];
				bqc_pkg::BQC_R_REWR:
					codepoint_rewrite_table[wr_mix[3:0]] <= reg_wdata[5:0];
				default:
					;
			endcase
		end
	end

	// Read mux; unmapped addresses and idle cycles read zero
	always_comb
	begin
		custom_service_tpid_d = custom_service_tpid_q;
		if (reg_wr && (wr_reg == bqc_pkg::BQC_R_TPID))
			custom_service_tpid_d = reg_wdata[15:0];
		rdata_d = 32'h0000_0000;
		if (reg_rd)
		begin
			case (rd_reg)
				bqc_pkg::BQC_R_TPID:
					rdata_d = {16'h0000, custom_service_tpid_q};
				bqc_pkg::BQC_R_COUNT:
					rdata_d = frame_count_q;
				bqc_pkg::BQC_R_FLOW:
					if (port_ok(rd_pix))
						rdata_d = 32'(port_classification_flow_config[rd_pix]);
				bqc_pkg::BQC_R_TAG:
					if (port_ok(rd_pix))
						rdata_d = 32'(port_tag_default_config[rd_pix]);
				bqc_pkg::BQC_R_MAP:
					if (port_ok(rd_mix[7:4]))
						rdata_d = 32'(tag_priority_map_table[rd_mix]);
				bqc_pkg::BQC_R_CP:
					rdata_d = 32'(per_codepoint_config[rd_mix[5:0]]);
				bqc_pkg::BQC_R_REWR:
					rdata_d = 32'(codepoint_rewrite_table[rd_mix[3:0]]);
				default:
					rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Per-frame configuration of the ingress port
	logic [FCW-1:0] fcfg;
	logic [TDW-1:0] tcfg;
	logic           port_in_range;

	always_comb
	begin
		port_in_range = port_ok(frm_port);
		fcfg = port_in_range ? port_classification_flow_config[frm_port] : bqc_pkg::FLOW_CFG_RST;
		tcfg = port_in_range ? port_tag_default_config[frm_port] : bqc_pkg::TAG_DFLT_RST;
	end

	// Tag recognition and selection
	logic [1:0]  tag_cnt;
	logic        tag_found;
	logic        tag_s;
	logic [2:0]  tag_pcp;
	logic        tag_dei;
	logic [11:0] tag_vid;

	bqc_tag_sel u_tag_sel (
		.tpid_outer  (frm_tpid_outer),
		.tci_outer   (frm_tci_outer),
		.tpid_inner  (frm_tpid_inner),
		.tci_inner   (frm_tci_inner),
		.tpid_third  (frm_tpid_third),
		.custom_tpid (custom_service_tpid_q),
		.use_second  (fcfg[bqc_pkg::FC_SECOND]),
		.tag_cnt     (tag_cnt),
		.tag_found   (tag_found),
		.tag_s       (tag_s),
		.tag_pcp     (tag_pcp),
		.tag_dei     (tag_dei),
		.tag_vid     (tag_vid)
	);

	// The parser finds the codepoint behind zero to two tags; a third tag
	// makes the frame non-IP here so no stale layer three field leaks in
	logic       is_ip;
	logic [5:0] frame_dscp;

	always_comb
	begin
		is_ip = frm_is_ip && fcfg[bqc_pkg::FC_L3_EN] && (tag_cnt != 2'd3);
		frame_dscp = is_ip ? frm_dscp : 6'h00;
	end

	// Shared codepoint translation
	logic [5:0] xl_dscp;
	logic       xl_trust;
	logic [2:0] xl_qos;
	logic       xl_dp;

	bqc_dscp_xlat u_xlat (
		.dscp_in  (frame_dscp),
		.xlat_en  (fcfg[bqc_pkg::FC_XLAT_EN] && is_ip),
		.cp_cfg   (per_codepoint_config[frame_dscp]),
		.dscp_out (xl_dscp),
		.trusted  (xl_trust),
		.cp_qos   (xl_qos),
		.cp_dp    (xl_dp)
	);

	// Class, precedence and codepoint decision
	logic [2:0]  qos_c;
	logic        dp_c;
	logic [5:0]  dscp_c;
	logic [3:0]  map_ent;
	logic [7:0]  map_ix;
	logic        s_c;
	logic [2:0]  pcp_c;
	logic        dei_c;
	logic [11:0] vid_c;
	logic [1:0]  strip_c;
	logic [1:0]  strip_cfg;
	logic [1:0]  tags_present;

	always_comb
	begin
		map_ix  = {frm_port, tag_dei, tag_pcp};
		map_ent = port_in_range ? tag_priority_map_table[map_ix] : bqc_pkg::PRIO_MAP_RST;
		// Start from port defaults, then let tag and codepoint refine
		qos_c = fcfg[bqc_pkg::FC_QOS_LSB +: 3];
		dp_c  = fcfg[bqc_pkg::FC_DP];
		if (fcfg[bqc_pkg::FC_PCP_EN] && tag_found)
		begin
			qos_c = map_ent[2:0];
			dp_c  = map_ent[3];
		end
		if (fcfg[bqc_pkg::FC_DSCP_EN] && is_ip && xl_trust)
		begin
			qos_c = xl_qos;
			dp_c  = xl_dp;
		end
		dscp_c = is_ip ? xl_dscp : 6'h00;
		if (fcfg[bqc_pkg::FC_REWR_EN] && is_ip)
			dscp_c = codepoint_rewrite_table[{dp_c, qos_c}];
		if (ovr_cls_en)
		begin
			qos_c  = ovr_qos;
			dp_c   = ovr_drop_precedence;
			dscp_c = is_ip ? ovr_dscp : 6'h00;
		end
		// Precedence only ever goes up on excess, never down
		dp_c = dp_c | frm_cir_exceed;
		// Tag header from the frame when a tag exists, else port default
		if (tag_found)
		begin
			s_c   = tag_s;
			pcp_c = tag_pcp;
			dei_c = tag_dei;
			vid_c = tag_vid;
		end
		else
		begin
			s_c   = tcfg[bqc_pkg::TD_S_TAG];
			pcp_c = tcfg[bqc_pkg::TD_PCP_LSB +: 3];
			dei_c = tcfg[bqc_pkg::TD_DEI];
			vid_c = tcfg[bqc_pkg::TD_VID_LSB +: 12];
		end
		if (fcfg[bqc_pkg::FC_PRIO_QOS])
			pcp_c = qos_c;
		if (ovr_tag_en)
		begin
			s_c   = ovr_tag_s;
			pcp_c = ovr_pcp;
			dei_c = ovr_dei;
			vid_c = ovr_vid;
		end
		// Only two tags can be parsed, so never strip more than two
		strip_cfg    = fcfg[bqc_pkg::FC_STRIP_LSB +: 2];
		tags_present = (tag_cnt == 2'd3) ? 2'd2 : tag_cnt;
		strip_c      = (strip_cfg > tags_present) ? tags_present : strip_cfg;
	end

	// Output stage next values; all fields move in one edge
	logic        v_d;
	logic [2:0]  qos_d;
	logic        dp_d;
	logic [5:0]  dscp_d;
	logic        s_d;
	logic [2:0]  pcp_d;
	logic        dei_d;
	logic [11:0] vid_d;
	logic [1:0]  strip_d;

	always_comb
	begin
		v_d     = frm_valid;
		qos_d   = cls_qos;
		dp_d    = cls_drop_precedence;
		dscp_d  = cls_dscp;
		s_d     = cls_tag_s;
		pcp_d   = cls_pcp;
		dei_d   = cls_dei;
		vid_d   = cls_vid;
		strip_d = cls_egress_strip_count;
		frame_count_d = frame_count_q;
		if (frm_valid)
		begin
			qos_d   = qos_c;
			dp_d    = dp_c;
			dscp_d  = dscp_c;
			s_d     = s_c;
			pcp_d   = pcp_c;
			dei_d   = dei_c;
			vid_d   = vid_c;
			strip_d = strip_c;
			frame_count_d = frame_count_q + 32'h0000_0001;
		end
	end

	// Output and status registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			custom_service_tpid_q  <= bqc_pkg::CUSTOM_TPID_RST;
			frame_count_q          <= 32'h0000_0000;
			rdata_q                <= 32'h0000_0000;
			cls_valid              <= 1'b0;
			cls_qos                <= 3'h0;
			cls_drop_precedence    <= 1'b0;
			cls_dscp               <= 6'h00;
			cls_tag_s              <= 1'b0;
			cls_pcp                <= 3'h0;
			cls_dei                <= 1'b0;
			cls_vid                <= 12'h000;
			cls_egress_strip_count <= 2'h0;
		end
		else
		begin
			custom_service_tpid_q  <= custom_service_tpid_d;
			frame_count_q          <= frame_count_d;
			rdata_q                <= rdata_d;
			cls_valid              <= v_d;
			cls_qos                <= qos_d;
			cls_drop_precedence    <= dp_d;
			cls_dscp               <= dscp_d;
			cls_tag_s              <= s_d;
			cls_pcp                <= pcp_d;
			cls_dei                <= dei_d;
			cls_vid                <= vid_d;
			cls_egress_strip_count <= strip_d;
		end
	end

	assign reg_rdata = rdata_q;
endmodule : bqc_classifier
`default_nettype wire

// ==== bqc_classifier_assertions.sv ====
// Port-level checks for the basic QoS and tag classifier
`timescale 1ns/1ps
`default_nettype none
module bqc_classifier_assertions #(
	parameter int NPORTS = 11,
	parameter int PW     = 4
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        frm_valid,
	input wire logic        frm_is_ip,
	input wire logic        frm_cir_exceed,
	input wire logic        ovr_cls_en,
	input wire logic [2:0]  ovr_qos,
	input wire logic        ovr_drop_precedence,
	input wire logic        ovr_tag_en,
	input wire logic [2:0]  ovr_pcp,
	input wire logic [11:0] ovr_vid,
	input wire logic        cls_valid,
	input wire logic [2:0]  cls_qos,
	input wire logic        cls_drop_precedence,
	input wire logic [5:0]  cls_dscp,
	input wire logic [2:0]  cls_pcp,
	input wire logic [11:0] cls_vid,
	input wire logic [1:0]  cls_egress_strip_count
);
	// Single domain, so one clock and one reset serve every property
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Every header gets its result exactly one cycle later
	a_result_latency: assert property (frm_valid |=> cls_valid)
		else $error("result did not follow the header by one cycle");
	// A result never appears without a header behind it
	a_result_cause: assert property (cls_valid |-> $past(frm_valid))
		else $error("result without a header");
	// Downstream may read results late, so they must hold between frames
	a_results_hold: assert property (!frm_valid |=>
		$stable({cls_qos, cls_drop_precedence, cls_dscp, cls_pcp, cls_vid}))
		else $error("results changed without a frame");
	// Policer excess always wins over any classified precedence
	a_excess_raises_dp: assert property (frm_valid && frm_cir_exceed |=> cls_drop_precedence)
		else $error("rate excess did not raise precedence");
	// Non-IP frames carry a zero codepoint
	a_non_ip_zero: assert property (frm_valid && !frm_is_ip |=> cls_dscp == 6'h00)
		else $error("non-IP frame has a nonzero codepoint");
	// Match stage replaces class and precedence
	a_class_override: assert property (frm_valid && ovr_cls_en |=>
		cls_qos == $past(ovr_qos) && cls_drop_precedence == ($past(ovr_drop_precedence) | $past(frm_cir_exceed)))
		else $error("class override not applied");
	// Tag override is applied last, over class-derived priority too
	a_tag_override: assert property (frm_valid && ovr_tag_en |=>
		cls_vid == $past(ovr_vid) && cls_pcp == $past(ovr_pcp))
		else $error("tag override not applied");
	// At most two tags are ever stripped
	a_strip_capped: assert property (cls_egress_strip_count != 2'h3)
		else $error("strip count above two");
endmodule : bqc_classifier_assertions
bind bqc_classifier bqc_classifier_assertions #(.NPORTS(NPORTS), .PW(PW)) bqc_classifier_assertions_i (
	.clk_sys, .rst_n, .frm_valid, .frm_is_ip, .frm_cir_exceed, .ovr_cls_en, .ovr_qos, .ovr_drop_precedence,
	.ovr_tag_en, .ovr_pcp, .ovr_vid, .cls_valid, .cls_qos, .cls_drop_precedence, .cls_dscp, .cls_pcp, .cls_vid,
	.cls_egress_strip_count
);
`default_nettype wire

// ==== bqc_parser_model.sv ====
// Parser side model: presents one frame header per call
`timescale 1ns/1ps
`default_nettype none
module bqc_parser_model #(
	parameter int PW = 4
) (
	input  wire logic        clk_sys,
	output logic             frm_valid,
	output logic [PW-1:0]    frm_port,
	output logic [4:0][15:0] t,
	output logic             frm_is_ip,
	output logic [5:0]       frm_dscp,
	output logic [29:0]      ov
);
	int n_sent = 0;

	initial {frm_valid, frm_port, t, frm_is_ip, frm_dscp, ov} = '0;

	// Header lines turn to junk once the valid cycle is over, so stale fields are never trusted
	task automatic send(input logic [PW-1:0] p, input logic [4:0][15:0] h, input logic ip,
		input logic [5:0] ds, input logic [29:0] o);
		@(posedge clk_sys);
		frm_valid <= 1'b1;
		frm_port  <= p;
		t         <= h;
		frm_is_ip <= ip;
		frm_dscp  <= ds;
		ov        <= o;
		@(posedge clk_sys);
		frm_valid <= 1'b0;
		{frm_port, t, frm_is_ip, frm_dscp, ov} <= ~{p, h, ip, ds, o};
		n_sent++;
	endtask : send
endmodule : bqc_parser_model
`default_nettype wire

// ==== test_bqc_classifier.sv ====
// Self-checking bench for the basic QoS and tag classifier
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h seen %h", n, e, g); end end
module test_bqc_classifier;
	localparam int PW = 4;
	// Untagged header: plain ethertype in the first tag position
	localparam logic [4:0][15:0] UNT = {16'h0800, 64'h0};
	logic             clk_sys = 1'b0;
	logic             rst_n = 1'b0;
	logic [11:0]      reg_addr = '0;
	logic [31:0]      reg_wdata = '0;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic [31:0]      reg_rdata;
	logic             frm_valid, frm_is_ip;
	logic [PW-1:0]    frm_port;
	logic [4:0][15:0] t;
	logic [5:0]       frm_dscp;
	logic [29:0]      ov;
	logic             cls_valid, cls_drop_precedence, cls_tag_s, cls_dei;
	logic [2:0]       cls_qos, cls_pcp;
	logic [5:0]       cls_dscp;
	logic [11:0]      cls_vid;
	logic [1:0]       cls_egress_strip_count;
	int               n_mismatch = 0;
	int               checks_done = 0;

	bqc_classifier #(.NPORTS(11), .PW(PW)) bqc_classifier_i (
		.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frm_valid, .frm_port,
		.frm_tpid_outer(t[4]), .frm_tci_outer(t[3]), .frm_tpid_inner(t[2]), .frm_tci_inner(t[1]),
		.frm_tpid_third(t[0]), .frm_is_ip, .frm_dscp, .frm_cir_exceed(ov[29]), .ovr_cls_en(ov[28]),
		.ovr_qos(ov[27:25]), .ovr_drop_precedence(ov[24]), .ovr_dscp(ov[23:18]), .ovr_tag_en(ov[17]),
		.ovr_tag_s(ov[16]), .ovr_pcp(ov[15:13]), .ovr_dei(ov[12]), .ovr_vid(ov[11:0]), .cls_valid, .cls_qos,
		.cls_drop_precedence, .cls_dscp, .cls_tag_s, .cls_pcp, .cls_dei, .cls_vid, .cls_egress_strip_count
	);
	bqc_parser_model #(.PW(PW)) bqc_parser_model_i (.clk_sys, .frm_valid, .frm_port, .t, .frm_is_ip, .frm_dscp, .ov);

	// 20 MHz core clock
	always #25 clk_sys = ~clk_sys;

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : rd

	// Result packs class, precedence, codepoint, kind, priority, DEI, VID, strip count
	task automatic frame(input logic [PW-1:0] p, input logic [4:0][15:0] h, input logic ip,
		input logic [5:0] ds, input logic [29:0] o, input logic [28:0] e);
		logic [28:0] seen;
		bqc_parser_model_i.send(p, h, ip, ds, o);
		#1;
		seen = {cls_qos, cls_drop_precedence, cls_dscp, cls_tag_s, cls_pcp, cls_dei, cls_vid, cls_egress_strip_count};
		`CHK("cls_valid", 1'b1, cls_valid)
		`CHK("result", e, seen)
	endtask : frame

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// About 90 cycles of work; a hang is cut off well after that
	initial
	begin
		#(3000 * 50);
		n_mismatch++;
		finish_test();
	end

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(12'h080, 32'h1000);
		rd(12'h0c0, 32'h1);
		rd(12'h000, 32'h88a8);
		wr(12'h004, 32'h5);
		rd(12'h004, 32'h0);
		wr(12'h0ac, 32'h7);
		rd(12'h0ac, 32'h0);
		rd(12'hffc, 32'h0);
		done("registers");
		wr(12'h088, 32'h100d);
		rd(12'h088, 32'h100d);
		frame(4'h2, UNT, 1'b0, 6'h2a, 30'h0, {3'h5, 1'h1, 6'h00, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		frame(4'h2, UNT, 1'b1, 6'h2a, 30'h0, {3'h5, 1'h1, 6'h2a, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		frame(4'h2, {16'h8100, 16'h0123, 16'h88a8, 16'h0456, 16'h0800}, 1'b1, 6'h2a, 30'h0,
			{3'h5, 1'h1, 6'h2a, 1'h0, 3'h0, 1'h0, 12'h123, 2'h0});
		frame(4'h2, {16'h8100, 16'h0123, 16'h8100, 16'h0456, 16'h8100}, 1'b1, 6'h2a, 30'h0,
			{3'h5, 1'h1, 6'h00, 1'h0, 3'h0, 1'h0, 12'h123, 2'h0});
		done("defaults");
		// Port 1 maps DEI 1, PCP 6 to precedence 1, class 3
		wr(12'h084, 32'h1010);
		wr(12'h478, 32'hb);
		frame(4'h1, {16'h8100, 16'hd123, 48'h0}, 1'b0, 6'h00, 30'h0,
			{3'h3, 1'h1, 6'h00, 1'h0, 3'h6, 1'h1, 12'h123, 2'h0});
		frame(4'h1, {16'h88a8, 16'hd000, 48'h0}, 1'b0, 6'h00, 30'h0,
			{3'h3, 1'h1, 6'h00, 1'h1, 3'h6, 1'h1, 12'h000, 2'h0});
		wr(12'h000, 32'h9100);
		frame(4'h1, {16'h9100, 16'h2005, 48'h0}, 1'b0, 6'h00, 30'h0,
			{3'h0, 1'h0, 6'h00, 1'h1, 3'h1, 1'h0, 12'h005, 2'h0});
		// Port 1 default header: service tag, priority 5, DEI set, VID 0x00a
		wr(12'h0c4, 32'h1b00a);
		frame(4'h1, UNT, 1'b0, 6'h00, 30'h0, {3'h0, 1'h0, 6'h00, 1'h1, 3'h5, 1'h1, 12'h00a, 2'h0});
		// Port 3 takes the inner tag and asks for three pops
		wr(12'h08c, 32'h1d00);
		frame(4'h3, {16'h88a8, 16'h0064, 16'h8100, 16'h4032, 16'h0800}, 1'b0, 6'h00, 30'h0,
			{3'h0, 1'h0, 6'h00, 1'h0, 3'h2, 1'h0, 12'h032, 2'h2});
		frame(4'h3, {16'h8100, 16'h0064, 16'h0800, 32'h0}, 1'b0, 6'h00, 30'h0,
			{3'h0, 1'h0, 6'h00, 1'h0, 3'h0, 1'h0, 12'h064, 2'h1});
		done("tags");
		// Both codepoints trusted to class 4, translated to 0x11
		wr(12'h8a8, 32'h251);
		wr(12'h844, 32'h251);
		wr(12'h910, 32'h33);
		wr(12'h090, 32'h1020);
		frame(4'h4, UNT, 1'b1, 6'h2a, 30'h0, {3'h4, 1'h0, 6'h2a, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		wr(12'h090, 32'h1060);
		frame(4'h4, UNT, 1'b1, 6'h2a, 30'h0, {3'h4, 1'h0, 6'h11, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		wr(12'h090, 32'h10a0);
		frame(4'h4, UNT, 1'b1, 6'h2a, 30'h0, {3'h4, 1'h0, 6'h33, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		wr(12'h090, 32'h0020);
		frame(4'h4, UNT, 1'b1, 6'h2a, 30'h0, {3'h0, 1'h0, 6'h00, 1'h0, 3'h0, 1'h0, 12'h001, 2'h0});
		done("codepoint");
		// Override class 6 codepoint 5 with rate excess, then a tag override on a non-IP frame
		wr(12'h090, 32'h1200);
		frame(4'h4, UNT, 1'b1, 6'h2a, 30'h3c140000, {3'h6, 1'h1, 6'h05, 1'h0, 3'h6, 1'h0, 12'h001, 2'h0});
		frame(4'h4, UNT, 1'b0, 6'h2a, 30'h1c177abc, {3'h6, 1'h0, 6'h00, 1'h1, 3'h3, 1'h1, 12'habc, 2'h0});
		rd(12'h004, bqc_parser_model_i.n_sent);
		done("override");
		finish_test();
	end
endmodule : test_bqc_classifier
`default_nettype wire
